// ---- src/fem_pkg.sv ----
/*
  shared constants, types and the address decoder of the flash and memory map block.
  assumes one processor clock domain and a synchronous active-low reset.
*/
package fem_pkg;

  // special function register offsets
  localparam logic [7:0] SFR_ERASE_TRIGGER = 8'h94;
  localparam logic [7:0] SFR_FLASH_WRITE_CONTROL = 8'hb2;
  localparam logic [7:0] SFR_ERASE_PAGE_NUMBER = 8'hb7;

  // fields of flash_write_control
  localparam int PWE_BIT = 0;
  localparam int ARM_BIT = 1;
  localparam int BUSY_BIT = 7;
  localparam logic [7:0] REG_RESET = 8'h00;

  // erase patterns and the erased byte value
  localparam logic [7:0] MASS_PATTERN = 8'haa;
  localparam logic [7:0] PAGE_PATTERN = 8'h55;
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  localparam logic [7:0] BLOCKED_BYTE = 8'h00;

  // address widths of each memory
  localparam int FLASH_AW = 16;
  localparam int EXTERNAL_DATA_RAM_AW = 11;
  localparam int CED_AW = 10;
  localparam int CFG_AW = 8;
  localparam int PRAM_AW = 12;
  localparam int PAGE_AW = 9;

  // data space windows
  localparam logic [15:0] EXTERNAL_DATA_RAM_LO = 16'h0000;
  localparam logic [15:0] EXTERNAL_DATA_RAM_HI = 16'h07ff;
  localparam logic [15:0] CED_LO = 16'h1000;
  localparam logic [15:0] CED_HI = 16'h13ff;
  localparam logic [15:0] CFG_LO = 16'h2000;
  localparam logic [15:0] CFG_HI = 16'h20ff;
  localparam logic [15:0] PRAM_LO = 16'h3000;
  localparam logic [15:0] PRAM_HI = 16'h3fff;

  // configuration cell holding the access pulse width select bit
  localparam logic [15:0] CFG_APW_ADDR = 16'h2010;
  localparam int APW_BIT = 0;

  // last offset of a page and of the whole array
  localparam logic [PAGE_AW-1:0] PAGE_LAST = 9'h1ff;
  localparam logic [FLASH_AW-1:0] FLASH_LAST = 16'hffff;

  typedef enum logic [2:0] {RG_NONE, RG_EXTERNAL_DATA_RAM, RG_CED, RG_CFG, RG_PRAM} fem_region_e;
  typedef enum logic [1:0] {ERS_IDLE, ERS_MASS, ERS_PAGE} fem_erase_e;

  // register port request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } fem_sfr_req_s;

  // external data request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [7:0] wdata;
  } fem_xreq_s;

  // which ram window an address falls in
  function automatic fem_region_e fem_decode(input logic [15:0] a);
    fem_region_e r;
    r = RG_NONE;
    if (a <= EXTERNAL_DATA_RAM_HI) begin
      r = RG_EXTERNAL_DATA_RAM;
    end else if (a >= CED_LO && a <= CED_HI) begin
      r = RG_CED;
    end else if (a >= CFG_LO && a <= CFG_HI) begin
      r = RG_CFG;
    end else if (a >= PRAM_LO && a <= PRAM_HI) begin
      r = RG_PRAM;
    end
    return r;
  endfunction

endpackage

// ---- src/fem_ram.sv ----
/*
  single port byte memory with synchronous write and registered read.
  assumes the owner never needs read and write of different cells in one cycle.
*/
`timescale 1ns/100ps
`default_nettype none

module fem_ram import fem_pkg::*; #(
  parameter int AW = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic we,
  input wire logic [AW-1:0] addr,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata
);

  // storage, no reset: contents survive a processor reset
  logic [7:0] mem_r [0:(1<<AW)-1];

  ////////////////////////////////////////////////////////////////////////////
  // write port
  always_ff @(posedge clk) begin
    if (we) begin
      mem_r[addr] <= wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registered read, cleared by reset so the output is defined
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata <= REG_RESET;
    end else begin
      rdata <= mem_r[addr];
    end
  end

endmodule
`default_nettype wire

// ---- src/fem_erase_seq.sv ----
/*
  erase sweep engine: walks a page or the whole array one byte per clock.
  assumes the caller only starts it while idle and gives it the flash port while busy.
*/
`timescale 1ns/100ps
`default_nettype none

module fem_erase_seq import fem_pkg::*; (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic start_mass,
  input wire logic start_page,
  input wire logic [6:0] page,
  output logic busy,
  output logic [FLASH_AW-1:0] addr
);

  fem_erase_e state_r; // sweep state
  logic [FLASH_AW-1:0] cnt_r; // byte being erased

  ////////////////////////////////////////////////////////////////////////////
  // sweep state and address counter
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_r <= ERS_IDLE;
      cnt_r <= '0;
    end else begin
      unique case (state_r)
        ERS_IDLE: begin
          if (start_mass) begin
            state_r <= ERS_MASS;
            cnt_r <= '0;
          end else if (start_page) begin
            state_r <= ERS_PAGE;
            cnt_r <= {page, {PAGE_AW{1'b0}}};
          end
        end
        ERS_MASS: begin
          // one pass over the whole array
          if (cnt_r == FLASH_LAST) begin
            state_r <= ERS_IDLE;
          end
          cnt_r <= cnt_r + 16'h0001;
        end
        ERS_PAGE: begin
          // stops at the last byte of the page
          if (cnt_r[PAGE_AW-1:0] == PAGE_LAST) begin
            state_r <= ERS_IDLE;
          end
          cnt_r <= cnt_r + 16'h0001;
        end
      endcase
    end
  end

  assign busy = (state_r != ERS_IDLE);
  assign addr = cnt_r;

endmodule
`default_nettype wire

// ---- src/fem_top.sv ----
/*
  flash sequencer and data memory map seen by the processor core.
  holds the flash array, the ram windows, the erase control registers and the
  redirect of data stores into flash. assumes the core drives the register
  port and the data/code ports synchronously to clk and honours the ready outputs.
*/
`timescale 1ns/100ps
`default_nettype none

// Overview of operation
// - flash spans 0000-FFFF, 64 kilobytes
// - 2 kilobyte processor ram at 0000-07FF
// - engine data ram readable and writable
// - config ram and engine program ram windows
// - engine program ram blocked while engine runs
// - arm bit then 0xAA starts mass erase
// - mass erase only with emulator port enabled
// - page number bits 7:1, then 0x55
// - erase only on exact ordered pattern
// - write enable routes data stores to flash
// - erased bytes read as all ones
// - flash writes also land in shared ram
// - one bit selects flash access pulse width
module fem_top import fem_pkg::*; (
  input wire logic clk,
  input wire logic rst_n,
  input wire fem_sfr_req_s sfr_req,
  output logic [7:0] sfr_rdata,
  output logic sfr_rvalid,
  input wire fem_xreq_s xreq,
  output logic x_ready,
  output logic [7:0] x_rdata,
  output logic x_rvalid,
  input wire logic code_rd,
  input wire logic [15:0] code_addr,
  output logic code_ready,
  output logic [7:0] code_rdata,
  output logic code_rvalid,
  input wire logic engine_running,
  input wire logic in_circuit_emulator_port,
  output logic access_pulse_width_select,
  output logic flash_busy
);

  ////////////////////////////////////////////////////////////////////////////
  // declarations
  logic program_write_enable_r; // stores go to flash
  logic mass_erase_arm_r; // first step of mass erase done
  logic [7:0] erase_page_number_r; // page in bits 7:1
  logic apw_r; // pulse width select bit
  logic trig_wr; // write to erase_trigger
  logic start_mass;
  logic start_page;
  logic erase_busy;
  logic [FLASH_AW-1:0] erase_addr;
  logic acc_wr; // data store accepted
  logic acc_rd; // data load accepted
  logic flash_xwr; // store redirected to flash
  fem_region_e region; // window of the data address
  fem_region_e rd_region_r; // window of the pending load
  logic flash_we;
  logic [FLASH_AW-1:0] flash_addr;
  logic [7:0] flash_wdata;
  logic [7:0] flash_rdata;
  logic [7:0] external_data_ram_rdata;
  logic [7:0] ced_rdata;
  logic [7:0] cfg_rdata;
  logic [7:0] pram_rdata;
  logic external_data_ram_we;
  logic ced_we;
  logic cfg_we;
  logic pram_we;

  ////////////////////////////////////////////////////////////////////////////
  // erase trigger decode
  assign trig_wr = sfr_req.wr && (sfr_req.addr == SFR_ERASE_TRIGGER);
  assign start_mass = trig_wr && (sfr_req.wdata == MASS_PATTERN) && mass_erase_arm_r
                      && in_circuit_emulator_port && !erase_busy;
  assign start_page = trig_wr && (sfr_req.wdata == PAGE_PATTERN) && !erase_busy;

  ////////////////////////////////////////////////////////////////////////////
  // flash_write_control register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      program_write_enable_r <= 1'b0;
      mass_erase_arm_r <= 1'b0;
    end else if (sfr_req.wr && sfr_req.addr == SFR_FLASH_WRITE_CONTROL) begin
      program_write_enable_r <= sfr_req.wdata[PWE_BIT];
      mass_erase_arm_r <= sfr_req.wdata[ARM_BIT];
    end else if (trig_wr) begin
      // arm consumed by any trigger
      // a stray write must re-arm, so one old arm cannot serve a later trigger
      mass_erase_arm_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // erase_page_number register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      erase_page_number_r <= REG_RESET;
    end else if (sfr_req.wr && sfr_req.addr == SFR_ERASE_PAGE_NUMBER) begin
      erase_page_number_r <= sfr_req.wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register read back, one cycle after the request
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sfr_rdata <= REG_RESET;
      sfr_rvalid <= 1'b0;
    end else begin
      sfr_rvalid <= sfr_req.rd;
      if (sfr_req.addr == SFR_FLASH_WRITE_CONTROL) begin
        sfr_rdata <= {erase_busy, 5'h00, mass_erase_arm_r, program_write_enable_r};
      end else if (sfr_req.addr == SFR_ERASE_PAGE_NUMBER) begin
        sfr_rdata <= erase_page_number_r;
      end else begin
        // trigger is write only; unknown offsets read zero
        sfr_rdata <= REG_RESET;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // erase engine
  fem_erase_seq u_erase (
    .clk(clk),
    .rst_n(rst_n),
    .start_mass(start_mass),
    .start_page(start_page),
    .page(erase_page_number_r[7:1]),
    .busy(erase_busy),
    .addr(erase_addr)
  );
  assign flash_busy = erase_busy;

  ////////////////////////////////////////////////////////////////////////////
  // data port acceptance: data and code ports stall during an erase sweep
  assign x_ready = !erase_busy;
  assign acc_wr = xreq.wr && !erase_busy;
  assign acc_rd = xreq.rd && !erase_busy;
  assign region = fem_decode(xreq.addr);
  assign flash_xwr = acc_wr && program_write_enable_r;
  // a redirected store owns the flash port, so code fetch waits
  assign code_ready = !erase_busy && !flash_xwr;

  ////////////////////////////////////////////////////////////////////////////
  // flash port: erase sweep, then redirected store, then code fetch
  always_comb begin
    flash_we = 1'b0;
    flash_addr = code_addr;
    flash_wdata = xreq.wdata;
    if (erase_busy) begin
      flash_we = 1'b1;
      flash_addr = erase_addr;
      flash_wdata = ERASED_BYTE;
    end else if (flash_xwr) begin
      flash_we = 1'b1;
      flash_addr = xreq.addr;
    end
  end

  fem_ram #(.AW(FLASH_AW)) u_flash (
    .clk(clk),
    .rst_n(rst_n),
    .we(flash_we),
    .addr(flash_addr),
    .wdata(flash_wdata),
    .rdata(flash_rdata)
  );

  // code fetch answer
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      code_rvalid <= 1'b0;
    end else begin
      code_rvalid <= code_rd && code_ready;
    end
  end
  assign code_rdata = flash_rdata;

  ////////////////////////////////////////////////////////////////////////////
  // ram write enables; a redirected store writes the shared cell as well
  // shared ram cell written
  assign external_data_ram_we = acc_wr && (region == RG_EXTERNAL_DATA_RAM);
  assign ced_we = acc_wr && (region == RG_CED);
  assign cfg_we = acc_wr && (region == RG_CFG);
  assign pram_we = acc_wr && (region == RG_PRAM) && !engine_running;

  fem_ram #(.AW(EXTERNAL_DATA_RAM_AW)) u_external_data_ram (
    .clk(clk),
    .rst_n(rst_n),
    .we(external_data_ram_we),
    .addr(xreq.addr[EXTERNAL_DATA_RAM_AW-1:0]),
    .wdata(xreq.wdata),
    .rdata(external_data_ram_rdata)
  );

  fem_ram #(.AW(CED_AW)) u_ced (
    .clk(clk),
    .rst_n(rst_n),
    .we(ced_we),
    .addr(xreq.addr[CED_AW-1:0]),
    .wdata(xreq.wdata),
    .rdata(ced_rdata)
  );

  fem_ram #(.AW(CFG_AW)) u_cfg (
    .clk(clk),
    .rst_n(rst_n),
    .we(cfg_we),
    .addr(xreq.addr[CFG_AW-1:0]),
    .wdata(xreq.wdata),
    .rdata(cfg_rdata)
  );

  fem_ram #(.AW(PRAM_AW)) u_pram (
    .clk(clk),
    .rst_n(rst_n),
    .we(pram_we),
    .addr(xreq.addr[PRAM_AW-1:0]),
    .wdata(xreq.wdata),
    .rdata(pram_rdata)
  );

  ////////////////////////////////////////////////////////////////////////////
  // pulse width select shadows its configuration cell
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      apw_r <= 1'b0;
    end else if (acc_wr && xreq.addr == CFG_APW_ADDR) begin
      apw_r <= xreq.wdata[APW_BIT];
    end
  end
  assign access_pulse_width_select = apw_r;

  ////////////////////////////////////////////////////////////////////////////
  // data load tracking; a blocked program ram load answers zero
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rd_region_r <= RG_NONE;
      x_rvalid <= 1'b0;
    end else begin
      x_rvalid <= acc_rd;
      if (acc_rd && !(region == RG_PRAM && engine_running)) begin
        rd_region_r <= region;
      end else begin
        rd_region_r <= RG_NONE;
      end
    end
  end

  // selects among ram outputs, which are themselves registers
  always_comb begin
    unique case (rd_region_r)
      RG_EXTERNAL_DATA_RAM: x_rdata = external_data_ram_rdata;
      RG_CED: x_rdata = ced_rdata;
      RG_CFG: x_rdata = cfg_rdata;
      RG_PRAM: x_rdata = pram_rdata;
      default: x_rdata = BLOCKED_BYTE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  mass_start_a: assert property (
    trig_wr && sfr_req.wdata == MASS_PATTERN && mass_erase_arm_r
    && in_circuit_emulator_port && !erase_busy |=> erase_busy && erase_addr == 16'h0000)
    else $error("mass erase did not start");

  mass_gate_a: assert property (
    trig_wr && !in_circuit_emulator_port && sfr_req.wdata != PAGE_PATTERN
    && !erase_busy |=> !erase_busy)
    else $error("mass erase started without emulator port");

  page_start_a: assert property (
    trig_wr && sfr_req.wdata == PAGE_PATTERN && !erase_busy
    |=> erase_busy && erase_addr == {erase_page_number_r[7:1], 9'h000})
    else $error("page erase did not start at page base");

  arm_order_a: assert property (
    trig_wr && !mass_erase_arm_r && sfr_req.wdata != PAGE_PATTERN
    && !erase_busy |=> !erase_busy)
    else $error("erase started without arm");

  bad_pattern_a: assert property (
    trig_wr && sfr_req.wdata != PAGE_PATTERN && sfr_req.wdata != MASS_PATTERN
    && !erase_busy |=> (!erase_busy)[*2])
    else $error("stray trigger value started an erase");

  store_route_a: assert property (
    xreq.wr && program_write_enable_r && !erase_busy
    |-> flash_we && flash_addr == xreq.addr && flash_wdata == xreq.wdata)
    else $error("store not routed to flash");

  erase_ones_a: assert property (
    $rose(erase_busy) |-> flash_we && flash_wdata == ERASED_BYTE ##1 flash_we)
    else $error("erase sweep not writing all ones");

  pram_lock_a: assert property (
    xreq.rd && !erase_busy && engine_running && region == RG_PRAM
    |=> x_rvalid && x_rdata == BLOCKED_BYTE)
    else $error("program ram readable while engine runs");

  shared_cell_a: assert property (
    xreq.wr && program_write_enable_r && !erase_busy && region == RG_EXTERNAL_DATA_RAM
    |-> external_data_ram_we && flash_we)
    else $error("flash store missed shared ram cell");

  page_len_a: assert property (
    start_page |=> erase_busy[*8])
    else $error("page erase ended early");

endmodule
`default_nettype wire

// ---- dv/fem_cpu_model.sv ----
/*
  processor side model: drives the register, data and code ports of the
  flash block one request at a time. assumes the bench calls its tasks
  from one process, each call entered just after a falling clock edge.
*/
`timescale 1ns/100ps
`default_nettype none

module fem_cpu_model import fem_pkg::*; (
  input wire logic clk,
  output var fem_sfr_req_s sfr_req,
  input wire logic [7:0] sfr_rdata,
  input wire logic sfr_rvalid,
  output var fem_xreq_s xreq,
  input wire logic x_ready,
  input wire logic [7:0] x_rdata,
  input wire logic x_rvalid,
  output logic code_rd,
  output logic [15:0] code_addr,
  input wire logic code_ready,
  input wire logic [7:0] code_rdata,
  input wire logic code_rvalid,
  output logic hang
);
  // idle bus at time zero, no request pending
  initial begin
    sfr_req = '0;
    xreq = '0;
    code_rd = 1'b0;
    code_addr = 16'h0000;
    hang = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // register access; address and data are inverted once released so a
  // stale value can never pass for a held one
  task automatic sfr_io(input logic wr, input logic [7:0] a, input logic [7:0] d,
                        output logic [7:0] q);
    sfr_req = '{wr: wr, rd: !wr, addr: a, wdata: d};
    @(posedge clk);
    @(negedge clk);
    sfr_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    // answer is checked at the falling edge half a cycle after the taking edge
    if (!wr && sfr_rvalid !== 1'b1) begin
      hang = 1'b1;
    end
    q = sfr_rdata;
    @(negedge clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // data load or store, held back while the block is not ready
  task automatic x_io(input logic wr, input logic [15:0] a, input logic [7:0] d,
                      output logic [7:0] q);
    int n;
    for (n = 0; n < 8 && x_ready !== 1'b1; n++) begin
      @(negedge clk);
    end
    if (x_ready !== 1'b1) begin
      hang = 1'b1;
    end
    xreq = '{wr: wr, rd: !wr, addr: a, wdata: d};
    @(posedge clk);
    @(negedge clk);
    xreq = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    if (!wr && x_rvalid !== 1'b1) begin
      hang = 1'b1;
    end
    q = x_rdata;
    @(negedge clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // code fetch; a redirected store may hold the port off for one cycle
  task automatic fetch(input logic [15:0] a, output logic [7:0] q);
    int n;
    for (n = 0; n < 8 && code_ready !== 1'b1; n++) begin
      @(negedge clk);
    end
    if (code_ready !== 1'b1) begin
      hang = 1'b1;
    end
    code_rd = 1'b1;
    code_addr = a;
    @(posedge clk);
    @(negedge clk);
    code_rd = 1'b0;
    code_addr = ~a;
    if (code_rvalid !== 1'b1) begin
      hang = 1'b1;
    end
    q = code_rdata;
    @(negedge clk);
  endtask
endmodule
`default_nettype wire

// ---- dv/flash_erase_write_memory_map_tb_top.sv ----
/*
  self-checking bench of the flash and memory map block.
  assumes the processor model above and a 200 MHz clock.
*/
`timescale 1ns/100ps
`default_nettype none

module flash_erase_write_memory_map_tb_top import fem_pkg::*;;
  logic clk, rst_n, engine_running, in_circuit_emulator_port, hang;
  fem_sfr_req_s sfr_req;
  fem_xreq_s xreq;
  logic [7:0] sfr_rdata, x_rdata, code_rdata, q;
  logic sfr_rvalid, x_ready, x_rvalid, code_rd, code_ready, code_rvalid;
  logic [15:0] code_addr;
  logic access_pulse_width_select, flash_busy;
  int err_count = 0;
  int samples_checked = 0;

  fem_top u_dut (.clk(clk), .rst_n(rst_n), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata),
    .sfr_rvalid(sfr_rvalid), .xreq(xreq), .x_ready(x_ready), .x_rdata(x_rdata),
    .x_rvalid(x_rvalid), .code_rd(code_rd), .code_addr(code_addr),
    .code_ready(code_ready), .code_rdata(code_rdata), .code_rvalid(code_rvalid),
    .engine_running(engine_running), .in_circuit_emulator_port(in_circuit_emulator_port),
    .access_pulse_width_select(access_pulse_width_select), .flash_busy(flash_busy));
  fem_cpu_model u_cpu (.clk(clk), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata),
    .sfr_rvalid(sfr_rvalid), .xreq(xreq), .x_ready(x_ready), .x_rdata(x_rdata),
    .x_rvalid(x_rvalid), .code_rd(code_rd), .code_addr(code_addr),
    .code_ready(code_ready), .code_rdata(code_rdata), .code_rvalid(code_rvalid),
    .hang(hang));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  // verdict and comparison
  task automatic conclude();
    if (err_count == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    samples_checked++;
    if (seen !== want) begin
      err_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask

  // a port that never answers ends the run
  always @(posedge hang) begin
    err_count++;
    conclude();
  end

  task automatic sw(input logic [7:0] a, input logic [7:0] d);
    u_cpu.sfr_io(1'b1, a, d, q);
  endtask
  task automatic sr_chk(input logic [7:0] a, input logic [7:0] w);
    u_cpu.sfr_io(1'b0, a, 8'h00, q);
    check(q, w);
  endtask
  task automatic xw(input logic [15:0] a, input logic [7:0] d);
    u_cpu.x_io(1'b1, a, d, q);
  endtask
  task automatic xr_chk(input logic [15:0] a, input logic [7:0] w);
    u_cpu.x_io(1'b0, a, 8'h00, q);
    check(q, w);
  endtask
  task automatic cf_chk(input logic [15:0] a, input logic [7:0] w);
    u_cpu.fetch(a, q);
    check(q, w);
  endtask
  // a sweep is bounded just above the full array length
  task automatic wait_idle();
    int n;
    for (n = 0; n < 70000 && flash_busy !== 1'b0; n++) begin
      @(negedge clk);
    end
    if (flash_busy !== 1'b0) begin
      err_count++;
      conclude();
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_reset();
    sr_chk(SFR_FLASH_WRITE_CONTROL, REG_RESET);
    sr_chk(SFR_ERASE_PAGE_NUMBER, REG_RESET);
    sr_chk(SFR_ERASE_TRIGGER, 8'h00);
    check({7'h00, access_pulse_width_select}, 8'h00);
  endtask

  // window table skips the critical setting cells
  logic [15:0] win[8] = '{16'h0000, 16'h07ff, 16'h1000, 16'h13ff,
                          16'h2008, 16'h20ff, 16'h3000, 16'h3fff};
  logic [15:0] gap[4] = '{16'h0800, 16'h1400, 16'h2100, 16'h4000};
  task automatic t_windows();
    foreach (win[i]) xw(win[i], win[i][7:0] ^ 8'h3c);
    foreach (win[i]) xr_chk(win[i], win[i][7:0] ^ 8'h3c);
    foreach (gap[i]) xr_chk(gap[i], 8'h00);
  endtask

  task automatic t_engine();
    engine_running = 1'b1;
    xw(16'h3000, 8'h99);
    xr_chk(16'h3000, BLOCKED_BYTE);
    xr_chk(16'h1000, 8'h3c);
    engine_running = 1'b0;
    xr_chk(16'h3000, 8'h3c);
  endtask

  task automatic t_page();
    // no interrupt source here
    // the bench runs one process, so stores are never interrupted
    sw(SFR_FLASH_WRITE_CONTROL, 8'h01);
    xw(16'h4200, 8'h11);
    xw(16'h3fff, 8'h22);
    // write enable dropped after the stores
    sw(SFR_FLASH_WRITE_CONTROL, 8'h00);
    xr_chk(16'h3fff, 8'h22);
    sw(SFR_ERASE_PAGE_NUMBER, 8'h40);
    sr_chk(SFR_ERASE_PAGE_NUMBER, 8'h40);
    sw(SFR_ERASE_TRIGGER, PAGE_PATTERN);
    check({7'h00, flash_busy}, 8'h01);
    check({7'h00, x_ready}, 8'h00);
    sr_chk(SFR_FLASH_WRITE_CONTROL, 8'h80);
    wait_idle();
    cf_chk(16'h4000, ERASED_BYTE);
    cf_chk(16'h41ff, ERASED_BYTE);
    cf_chk(16'h4200, 8'h11);
    cf_chk(16'h3fff, 8'h22);
  endtask

  task automatic t_redirect();
    sw(SFR_FLASH_WRITE_CONTROL, 8'h01);
    xw(16'h4000, 8'h5a);
    xw(16'h0100, 8'hc3);
    sw(SFR_FLASH_WRITE_CONTROL, 8'h00);
    cf_chk(16'h4000, 8'h5a);
    cf_chk(16'h0100, 8'hc3);
    xr_chk(16'h0100, 8'hc3);
    xw(16'h4001, 8'h77);
    xw(16'h0100, 8'h3c);
    cf_chk(16'h4001, ERASED_BYTE);
    cf_chk(16'h0100, 8'hc3);
    xr_chk(16'h0100, 8'h3c);
  endtask

  logic [7:0] bad[6] = '{8'h00, 8'hab, 8'h54, 8'hff, 8'h56, 8'ha9};
  task automatic t_refuse();
    in_circuit_emulator_port = 1'b1;
    foreach (bad[i]) begin
      sw(SFR_ERASE_TRIGGER, bad[i]);
      check({7'h00, flash_busy}, 8'h00);
    end
    sw(SFR_ERASE_TRIGGER, MASS_PATTERN);
    check({7'h00, flash_busy}, 8'h00);
    sw(SFR_FLASH_WRITE_CONTROL, 8'h02);
    sr_chk(SFR_FLASH_WRITE_CONTROL, 8'h02);
    in_circuit_emulator_port = 1'b0;
    sw(SFR_ERASE_TRIGGER, MASS_PATTERN);
    check({7'h00, flash_busy}, 8'h00);
    sr_chk(SFR_FLASH_WRITE_CONTROL, 8'h00);
    cf_chk(16'h4000, 8'h5a);
  endtask

  task automatic t_mass();
    in_circuit_emulator_port = 1'b1;
    sw(SFR_FLASH_WRITE_CONTROL, 8'h02);
    sw(SFR_ERASE_TRIGGER, MASS_PATTERN);
    check({7'h00, flash_busy}, 8'h01);
    check({7'h00, code_ready}, 8'h00);
    wait_idle();
    cf_chk(16'h0000, ERASED_BYTE);
    cf_chk(16'h4000, ERASED_BYTE);
    cf_chk(FLASH_LAST, ERASED_BYTE);
  endtask

  task automatic t_pulse();
    xw(CFG_APW_ADDR, 8'h01);
    check({7'h00, access_pulse_width_select}, 8'h01);
    xw(CFG_APW_ADDR, 8'h00);
    check({7'h00, access_pulse_width_select}, 8'h00);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    rst_n = 1'b0;
    engine_running = 1'b0;
    in_circuit_emulator_port = 1'b0;
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    t_reset();
    t_windows();
    t_engine();
    t_pulse();
    t_page();
    t_redirect();
    t_refuse();
    t_mass();
    conclude();
  end
endmodule
`default_nettype wire
